// ==== rtl/opmode_defines.vh ====
`ifndef OPMODE_DEFINES_VH
`define OPMODE_DEFINES_VH

// ==========================================================
// register byte addresses on the wishbone slave
`define OM_ADR_W            8
`define OM_ADR_MODE         8'h00
`define OM_ADR_IDLE         8'h04

// ==========================================================
// system_mode_control fields
`define OM_BIT_HLS          0
`define OM_BIT_IDLE_SEL     1
`define OM_BIT_HS_RDY       2
`define OM_BIT_LS_RDY       3
`define OM_BIT_FAST         4
`define OM_CKS_LO           5
`define OM_CKS_HI           7
`define OM_MODE_RST         8'h03
`define OM_MODE_WMASK       8'hF3

// ==========================================================
// idle_clock_and_reset_flags fields
`define OM_BIT_KEEP         7
`define OM_FLAGS_LO         0
`define OM_FLAGS_HI         2
`define OM_IDLE_RST         8'h00
`define OM_IDLE_WMASK       8'h87

// ==========================================================
// clock-select decoding
`define OM_CKS_FIRST_DIV    3'h2
`define OM_CKS_MAX_SHIFT    3'h6
`define OM_DIV_W            6

// ==========================================================
// system clock source codes
`define OM_SRC_NONE         2'h0
`define OM_SRC_HS           2'h1
`define OM_SRC_DIV          2'h2
`define OM_SRC_SUB          2'h3

// ==========================================================
// reported operating mode codes
`define OM_MODE_NORMAL      3'h0
`define OM_MODE_SLOW        3'h1
`define OM_MODE_IDLE_OFF    3'h2
`define OM_MODE_IDLE_ON     3'h3
`define OM_MODE_DEEP        3'h4
`define OM_MODE_LIGHT       3'h5
`define OM_MODE_FAST_WAKE   3'h6

// ==========================================================
// oscillator settling counts, in oscillator cycles
`define OM_CNT_W            10
`define OM_HS_XTAL_CYC      10'h200
`define OM_HS_RC_CYC        10'h010
`define OM_LS_XTAL_CYC      10'h080
`define OM_LS_RC_CYC        10'h002

`endif

// ==== rtl/osc_ready_timer.v ====
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// oscillator settle timer
// ready drops at once when the oscillator is stopped and rises
// after the configured number of oscillator ticks
module osc_ready_timer #(
	parameter                  CNT_W    = 10,
	parameter [CNT_W-1:0]      XTAL_CYC = 10'h200,
	parameter [CNT_W-1:0]      RC_CYC   = 10'h010
) (
	input  wire                i_ref_clk,
	input  wire                i_sys_rst,
	input  wire                i_osc_on,
	input  wire                i_osc_tick,
	input  wire                i_crystal,
	output reg                 o_ready_ff
);

	reg  [CNT_W-1:0]           cnt_ff;
	wire [CNT_W-1:0]           target;
	wire [CNT_W-1:0]           last;

	assign target = i_crystal ? XTAL_CYC : RC_CYC;
	assign last   = target - {{(CNT_W-1){1'b0}}, 1'b1};

	always @(posedge i_ref_clk) begin
		if (i_sys_rst || !i_osc_on) begin
			cnt_ff     <= {CNT_W{1'b0}};
			o_ready_ff <= 1'b0;
		end else if (!o_ready_ff && i_osc_tick) begin
			if (cnt_ff == last) begin
				o_ready_ff <= 1'b1;
			end
			cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule

`default_nettype wire

// ==== rtl/operating_mode_clock_select.v ====
`timescale 1ns/10ps
`default_nettype none
`include "opmode_defines.vh"

module operating_mode_clock_select #(
	parameter                  HS_XTAL_CYC = `OM_HS_XTAL_CYC,
	parameter                  HS_RC_CYC   = `OM_HS_RC_CYC,
	parameter                  LS_XTAL_CYC = `OM_LS_XTAL_CYC,
	parameter                  LS_RC_CYC   = `OM_LS_RC_CYC
) (
	input  wire                i_ref_clk,
	input  wire                i_sys_rst,
	input  wire                i_wb_cyc,
	input  wire                i_wb_stb,
	input  wire                i_wb_we,
	input  wire [7:0]          i_wb_adr,
	input  wire [3:0]          i_wb_sel,
	input  wire [31:0]         i_wb_dat,
	output reg  [31:0]         o_wb_dat_ff,
	output reg                 o_wb_ack_ff,
	input  wire                i_halt,
	input  wire                i_wake,
	input  wire                i_wdt_enable,
	input  wire                i_low_voltage_detect_enable,
	input  wire                i_high_speed_crystal,
	input  wire                i_low_speed_crystal,
	input  wire                i_hs_tick,
	input  wire                i_sub_tick,
	output reg                 o_cpu_run_ff,
	output reg                 o_sys_tick_ff,
	output reg  [1:0]          o_clk_src_ff,
	output reg                 o_hs_osc_en_ff,
	output reg                 o_sub_clk_en_ff,
	output reg                 o_wdt_run_ff,
	output reg                 o_tbc_en_ff,
	output reg  [2:0]          o_mode_ff
);

	// ======================================================
	// state codes
	localparam [2:0]           ST_RUN   = 3'h0;
	localparam [2:0]           ST_DEEP  = 3'h1;
	localparam [2:0]           ST_LIGHT = 3'h2;
	localparam [2:0]           ST_IOFF  = 3'h3;
	localparam [2:0]           ST_ION   = 3'h4;
	localparam [2:0]           ST_FAST  = 3'h5;

	// ======================================================
	// declarations
	reg  [7:0]                 mode_ctrl_ff;
	reg  [7:0]                 idle_ctrl_ff;
	reg  [2:0]                 state_ff;
	reg  [2:0]                 nxt_state;
	reg  [`OM_DIV_W-1:0]       div_cnt_ff;
	reg  [1:0]                 src;
	reg  [2:0]                 mode_code;
	reg                        src_ready;
	reg                        sys_tick;
	reg                        cpu_run;
	reg  [7:0]                 rd_data;

	wire                       hs_ready;
	wire                       ls_ready;
	wire                       hs_on;
	wire                       ls_on;
	wire [2:0]                 cks;
	wire                       sel_undiv;
	wire                       sel_high;
	wire                       idle_sel;
	wire                       fast_en;
	wire                       clock_keep;
	wire                       div_tick;
	wire                       halt_take;
	wire                       wake_fast;
	wire                       bus_req;
	wire                       bus_wr;

	// ======================================================
	// decoding helpers
	function [`OM_DIV_W-1:0] div_mask;
		input [2:0] sel;
		reg   [2:0] shift;
		begin
			shift    = `OM_CKS_MAX_SHIFT - (sel - `OM_CKS_FIRST_DIV);
			div_mask = ~({`OM_DIV_W{1'b1}} << shift);
		end
	endfunction

	function [7:0] merge_write;
		input [7:0] old;
		input [7:0] wdat;
		input [7:0] wmask;
		begin
			merge_write = (old & ~wmask) | (wdat & wmask);
		end
	endfunction

	// ======================================================
	// field views
	assign cks        = mode_ctrl_ff[`OM_CKS_HI:`OM_CKS_LO];
	assign sel_undiv  = mode_ctrl_ff[`OM_BIT_HLS];
	assign idle_sel   = mode_ctrl_ff[`OM_BIT_IDLE_SEL];
	assign fast_en    = mode_ctrl_ff[`OM_BIT_FAST];
	assign clock_keep = idle_ctrl_ff[`OM_BIT_KEEP];
	// field values 000/001 mean substitute clock unless the HLS bit is set
	assign sel_high   = sel_undiv || (cks >= `OM_CKS_FIRST_DIV);

	// ======================================================
	// wishbone slave, one wait state per access
	assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack_ff;
	assign bus_wr  = bus_req && i_wb_we && i_wb_sel[0];

	always @* begin
		case (i_wb_adr)
			`OM_ADR_MODE: begin
				rd_data = mode_ctrl_ff;
				rd_data[`OM_BIT_LS_RDY] = ls_ready;
				rd_data[`OM_BIT_HS_RDY] = hs_ready;
			end
			`OM_ADR_IDLE: begin
				rd_data = idle_ctrl_ff & `OM_IDLE_WMASK;
			end
			default: begin
				rd_data = 8'h00;
			end
		endcase
	end

	always @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_wb_ack_ff  <= 1'b0;
			o_wb_dat_ff  <= 32'h0000_0000;
			mode_ctrl_ff <= `OM_MODE_RST;
			idle_ctrl_ff <= `OM_IDLE_RST;
		end else begin
			o_wb_ack_ff <= bus_req;
			if (bus_req && !i_wb_we) begin
				o_wb_dat_ff <= {24'h00_0000, rd_data};
			end
			if (bus_wr && i_wb_adr == `OM_ADR_MODE) begin
				// ready flags are not storage; hardware owns them
				mode_ctrl_ff <= merge_write(mode_ctrl_ff, i_wb_dat[7:0], `OM_MODE_WMASK);
			end
			if (bus_wr && i_wb_adr == `OM_ADR_IDLE) begin
				idle_ctrl_ff <= merge_write(idle_ctrl_ff, i_wb_dat[7:0], `OM_IDLE_WMASK);
			end
		end
	end

	// ======================================================
	// oscillator control
	// high-speed runs only while a high-speed source is wanted
	assign hs_on = sel_high && (state_ff == ST_RUN || state_ff == ST_ION ||
	               state_ff == ST_FAST);
	assign ls_on = (state_ff != ST_DEEP);

	osc_ready_timer #(
		.CNT_W      (`OM_CNT_W),
		.XTAL_CYC   (HS_XTAL_CYC[`OM_CNT_W-1:0]),
		.RC_CYC     (HS_RC_CYC[`OM_CNT_W-1:0])
	) u_hs_ready (
		.i_ref_clk  (i_ref_clk),
		.i_sys_rst  (i_sys_rst),
		.i_osc_on   (hs_on),
		.i_osc_tick (i_hs_tick),
		.i_crystal  (i_high_speed_crystal),
		.o_ready_ff (hs_ready)
	);

	osc_ready_timer #(
		.CNT_W      (`OM_CNT_W),
		.XTAL_CYC   (LS_XTAL_CYC[`OM_CNT_W-1:0]),
		.RC_CYC     (LS_RC_CYC[`OM_CNT_W-1:0])
	) u_ls_ready (
		.i_ref_clk  (i_ref_clk),
		.i_sys_rst  (i_sys_rst),
		.i_osc_on   (ls_on),
		.i_osc_tick (i_sub_tick),
		.i_crystal  (i_low_speed_crystal),
		.o_ready_ff (ls_ready)
	);

	// ======================================================
	// high-speed prescaler
	// free running so a ratio change never waits a full wrap
	always @(posedge i_ref_clk) begin
		if (i_sys_rst || !hs_on) begin
			div_cnt_ff <= {`OM_DIV_W{1'b0}};
		end else if (i_hs_tick) begin
			div_cnt_ff <= div_cnt_ff + {{(`OM_DIV_W-1){1'b0}}, 1'b1};
		end
	end

	assign div_tick = i_hs_tick && ((div_cnt_ff & div_mask(cks)) == div_mask(cks));

	// ======================================================
	// system clock source and cpu gating
	always @* begin
		src = `OM_SRC_NONE;
		case (state_ff)
			ST_RUN, ST_ION: begin
				if (sel_undiv) begin
					src = `OM_SRC_HS;
				end else if (sel_high) begin
					src = `OM_SRC_DIV;
				end else begin
					src = `OM_SRC_SUB;
				end
			end
			ST_FAST: begin
				src = `OM_SRC_SUB;
			end
			default: begin
				src = `OM_SRC_NONE;
			end
		endcase
	end

	always @* begin
		case (src)
			`OM_SRC_HS: begin
				src_ready = hs_ready;
				sys_tick  = i_hs_tick && hs_ready;
			end
			`OM_SRC_DIV: begin
				src_ready = hs_ready;
				sys_tick  = div_tick && hs_ready;
			end
			`OM_SRC_SUB: begin
				src_ready = ls_ready;
				sys_tick  = i_sub_tick && ls_ready;
			end
			default: begin
				src_ready = 1'b0;
				sys_tick  = 1'b0;
			end
		endcase
		// cpu waits for the chosen clock to settle
		cpu_run = (state_ff == ST_RUN || state_ff == ST_FAST) && src_ready;
	end

	// ======================================================
	// operating mode sequencer
	assign halt_take = i_halt && cpu_run;
	// no substitute clock survives deep sleep, so no fast start there
	assign wake_fast = i_wake && state_ff != ST_DEEP && sel_high &&
	                   i_high_speed_crystal && fast_en;

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RUN: begin
				if (halt_take) begin
					if (idle_sel) begin
						nxt_state = clock_keep ? ST_ION : ST_IOFF;
					end else if (i_wdt_enable) begin
						nxt_state = ST_LIGHT;
					end else if (!i_low_voltage_detect_enable) begin
						nxt_state = ST_DEEP;
					end else begin
						nxt_state = ST_RUN;
					end
				end
			end
			ST_DEEP, ST_LIGHT, ST_IOFF: begin
				if (wake_fast) begin
					nxt_state = ST_FAST;
				end else if (i_wake) begin
					nxt_state = ST_RUN;
				end
			end
			ST_ION: begin
				if (i_wake) begin
					nxt_state = ST_RUN;
				end
			end
			ST_FAST: begin
				if (hs_ready) begin
					nxt_state = ST_RUN;
				end
			end
			default: begin
				nxt_state = ST_RUN;
			end
		endcase
	end

	always @* begin
		case (state_ff)
			ST_RUN:   mode_code = sel_high ? `OM_MODE_NORMAL : `OM_MODE_SLOW;
			ST_DEEP:  mode_code = `OM_MODE_DEEP;
			ST_LIGHT: mode_code = `OM_MODE_LIGHT;
			ST_IOFF:  mode_code = `OM_MODE_IDLE_OFF;
			ST_ION:   mode_code = `OM_MODE_IDLE_ON;
			ST_FAST:  mode_code = `OM_MODE_FAST_WAKE;
			default:  mode_code = `OM_MODE_NORMAL;
		endcase
	end

	// ======================================================
	// state and registered outputs
	always @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_ff        <= ST_RUN;
			o_cpu_run_ff    <= 1'b0;
			o_sys_tick_ff   <= 1'b0;
			o_clk_src_ff    <= `OM_SRC_NONE;
			o_hs_osc_en_ff  <= 1'b0;
			o_sub_clk_en_ff <= 1'b0;
			o_wdt_run_ff    <= 1'b0;
			o_tbc_en_ff     <= 1'b0;
			o_mode_ff       <= `OM_MODE_NORMAL;
		end else begin
			state_ff        <= nxt_state;
			o_cpu_run_ff    <= cpu_run;
			o_sys_tick_ff   <= sys_tick;
			o_clk_src_ff    <= src;
			o_hs_osc_en_ff  <= hs_on;
			o_sub_clk_en_ff <= ls_on;
			o_wdt_run_ff    <= i_wdt_enable && state_ff != ST_DEEP;
			// time base stops in both sleep states
			o_tbc_en_ff     <= state_ff != ST_DEEP && state_ff != ST_LIGHT;
			o_mode_ff       <= mode_code;
		end
	end

endmodule

`default_nettype wire

// ==== sim/opmode_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========
// port-level checks
module opmode_sva #(
	parameter HS_XTAL_CYC = 8,
	parameter HS_RC_CYC   = 4,
	parameter LS_XTAL_CYC = 4,
	parameter LS_RC_CYC   = 2
) (
	input wire logic        i_ref_clk,
	input wire logic        i_sys_rst,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [7:0]  i_wb_adr,
	input wire logic [31:0] o_wb_dat_ff,
	input wire logic        o_wb_ack_ff,
	input wire logic        i_low_voltage_detect_enable,
	input wire logic        i_hs_tick,
	input wire logic        o_cpu_run_ff,
	input wire logic        o_sys_tick_ff,
	input wire logic [1:0]  o_clk_src_ff,
	input wire logic        o_hs_osc_en_ff,
	input wire logic        o_sub_clk_en_ff,
	input wire logic        o_wdt_run_ff,
	input wire logic [2:0]  o_mode_ff
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	AST_ACK_NEXT:
	assert property (i_wb_cyc && i_wb_stb && !o_wb_ack_ff |=> o_wb_ack_ff) else $error("ack late");
	AST_ACK_ONE:
	assert property (o_wb_ack_ff |=> !o_wb_ack_ff) else $error("ack too long");
	AST_RSVD_ZERO:
	assert property (o_wb_ack_ff && !$past(i_wb_we) && $past(i_wb_adr) == 8'h04
		|-> o_wb_dat_ff[6:3] == 4'h0) else $error("unused bits nonzero");
	AST_DEEP_STOP:
	assert property (o_mode_ff == 3'h4 |-> !o_cpu_run_ff && !o_sub_clk_en_ff && !o_wdt_run_ff)
		else $error("deep sleep clocks running");
	AST_LIGHT_SUB:
	assert property (o_mode_ff == 3'h5 |-> o_sub_clk_en_ff && !o_cpu_run_ff) else $error("light sleep wrong");
	AST_IDLE_OFF:
	assert property (o_mode_ff == 3'h2 |-> !o_cpu_run_ff && o_clk_src_ff == 2'h0) else $error("idle off wrong");
	AST_IDLE_ON:
	assert property (o_mode_ff == 3'h3 |-> !o_cpu_run_ff && o_clk_src_ff != 2'h0) else $error("idle on wrong");
	AST_SLOW_HS_OFF:
	assert property (o_mode_ff == 3'h1 |-> o_clk_src_ff == 2'h3 && !o_hs_osc_en_ff) else $error("slow mode wrong");
	AST_LVD_BLOCK:
	assert property ($rose(o_mode_ff == 3'h4) |-> !$past(i_low_voltage_detect_enable, 2))
		else $error("deep sleep with detect on");
	AST_HS_TICK:
	// gated on cpu run: while the oscillator settles the tick is held back
	assert property (o_clk_src_ff == 2'h1 && $stable(o_clk_src_ff) && o_cpu_run_ff
		|-> o_sys_tick_ff == $past(i_hs_tick))
		else $error("system tick not from fast clock");
	AST_FAST_SUB:
	assert property (o_mode_ff == 3'h6 |-> o_clk_src_ff == 2'h3) else $error("fast wake source wrong");
endmodule
bind operating_mode_clock_select opmode_sva #(.HS_XTAL_CYC(HS_XTAL_CYC), .HS_RC_CYC(HS_RC_CYC),
	.LS_XTAL_CYC(LS_XTAL_CYC), .LS_RC_CYC(LS_RC_CYC)) i_sva (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.o_wb_dat_ff(o_wb_dat_ff), .o_wb_ack_ff(o_wb_ack_ff), .i_hs_tick(i_hs_tick),
	.i_low_voltage_detect_enable(i_low_voltage_detect_enable), .o_cpu_run_ff(o_cpu_run_ff),
	.o_sys_tick_ff(o_sys_tick_ff), .o_clk_src_ff(o_clk_src_ff), .o_hs_osc_en_ff(o_hs_osc_en_ff),
	.o_sub_clk_en_ff(o_sub_clk_en_ff), .o_wdt_run_ff(o_wdt_run_ff), .o_mode_ff(o_mode_ff));
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
	typedef struct packed {logic [7:0] w; logic [1:0] s; logic [2:0] m; logic h; logic [8:0] p;} row_t;
	logic        clk, rst, cyc, stb, we, halt, wake, wdt, lvd, high_speed_crystal, low_speed_crystal, hs_tick, sub_tick;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [2:0]  tcnt;
	logic [31:0] wdat, rdat;
	wire  [31:0] dat;
	wire         ack, cpu_run, sys_tick, hs_en, sub_en, wdt_run, tbc_en;
	wire  [1:0]  src;
	wire  [2:0]  mode;
	int          err_total, checks_done, i, k;
	row_t        rows [0:9];

	// short settle counts keep the run brief
	operating_mode_clock_select #(.HS_XTAL_CYC(10'h008), .HS_RC_CYC(10'h004), .LS_XTAL_CYC(10'h004),
		.LS_RC_CYC(10'h002)) i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat_ff(dat),
		.o_wb_ack_ff(ack), .i_halt(halt), .i_wake(wake), .i_wdt_enable(wdt),
		.i_low_voltage_detect_enable(lvd), .i_high_speed_crystal(high_speed_crystal), .i_low_speed_crystal(low_speed_crystal),
		.i_hs_tick(hs_tick), .i_sub_tick(sub_tick), .o_cpu_run_ff(cpu_run), .o_sys_tick_ff(sys_tick),
		.o_clk_src_ff(src), .o_hs_osc_en_ff(hs_en), .o_sub_clk_en_ff(sub_en), .o_wdt_run_ff(wdt_run),
		.o_tbc_en_ff(tbc_en), .o_mode_ff(mode));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ==========
	// oscillators tick only while enabled
	always @(posedge clk) begin
		tcnt <= rst ? 3'h0 : tcnt + 3'h1;
		hs_tick <= hs_en & tcnt[0];
		sub_tick <= sub_en & (tcnt == 3'h7);
	end

	// ==========
	// helpers
	task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task stop_test;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rdat = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			err_total++;
			stop_test;
		end
		@(posedge clk);
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 32'h0);
		check("register", rdat, {24'h0, e});
	endtask

	task wmode(input logic [2:0] e);
		k = 0;
		while (mode !== e && k < 3000) begin
			@(posedge clk);
			k++;
		end
		check("mode", {29'h0, mode}, {29'h0, e});
		if (k >= 3000)
			stop_test;
	endtask

	// cpu must be running, otherwise the halt is dropped
	task do_halt;
		k = 0;
		while (cpu_run !== 1'b1 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		if (cpu_run !== 1'b1) begin
			err_total++;
			stop_test;
		end
		repeat (2) @(posedge clk);
		halt <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
	endtask

	task do_wake;
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
	endtask

	initial begin
		rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hF; wdat = 32'h0;
		halt = 1'b0; wake = 1'b0; wdt = 1'b0; lvd = 1'b0; high_speed_crystal = 1'b1; low_speed_crystal = 1'b1;
		err_total = 0; checks_done = 0;
		rows = '{{8'h03, 2'h1, 3'h0, 1'b1, 9'h002}, {8'h42, 2'h2, 3'h0, 1'b1, 9'h080},
			{8'h62, 2'h2, 3'h0, 1'b1, 9'h040}, {8'h82, 2'h2, 3'h0, 1'b1, 9'h020},
			{8'hA2, 2'h2, 3'h0, 1'b1, 9'h010}, {8'hC2, 2'h2, 3'h0, 1'b1, 9'h008},
			{8'hE2, 2'h2, 3'h0, 1'b1, 9'h004}, {8'h02, 2'h3, 3'h1, 1'b0, 9'h008},
			{8'h22, 2'h3, 3'h1, 1'b0, 9'h008}, {8'h03, 2'h1, 3'h0, 1'b1, 9'h002}};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(8'h00, 8'h03);
		rd(8'h04, 8'h00);
		repeat (100) @(posedge clk);
		rd(8'h00, 8'h0F);
		for (i = 0; i < 10; i++) begin
			wb(1'b1, 8'h00, {24'h0, rows[i].w});
			k = 0;
			while (src !== rows[i].s && k < 3000) begin
				@(posedge clk);
				k++;
			end
			check("source", {30'h0, src}, {30'h0, rows[i].s});
			if (k >= 3000)
				stop_test;
			wmode(rows[i].m);
			check("hs enable", {31'h0, hs_en}, {31'h0, rows[i].h});
			repeat (3) begin
				k = 0;
				do begin
					@(posedge clk);
					k++;
				end while (sys_tick !== 1'b1 && k < 300);
			end
			check("tick period", k, {23'h0, rows[i].p});
		end
		// ==========
		// second register and bus corners
		wb(1'b1, 8'h04, 32'hFF);
		rd(8'h04, 8'h87);
		sel <= 4'h0;
		wb(1'b1, 8'h04, 32'h00);
		sel <= 4'hF;
		rd(8'h04, 8'h87);
		rd(8'h08, 8'h00);
		// ==========
		// halt and wake
		wb(1'b1, 8'h04, 32'h80);
		do_halt;
		wmode(3'h3);
		check("idle source", {30'h0, src}, 32'h1);
		do_wake;
		wmode(3'h0);
		wb(1'b1, 8'h04, 32'h00);
		do_halt;
		wmode(3'h2);
		check("idle time base", {31'h0, tbc_en}, 32'h1);
		rd(8'h00, 8'h0B);
		do_wake;
		wmode(3'h0);
		wb(1'b1, 8'h00, 32'h01);
		lvd <= 1'b1;
		do_halt;
		repeat (10) @(posedge clk);
		check("refused halt", {29'h0, mode}, 32'h0);
		lvd <= 1'b0;
		do_halt;
		wmode(3'h4);
		check("deep time base", {31'h0, tbc_en}, 32'h0);
		rd(8'h00, 8'h01);
		do_wake;
		wmode(3'h0);
		wdt <= 1'b1;
		do_halt;
		wmode(3'h5);
		check("light watchdog", {31'h0, wdt_run}, 32'h1);
		check("light time base", {31'h0, tbc_en}, 32'h0);
		do_wake;
		wmode(3'h0);
		wdt <= 1'b0;
		wb(1'b1, 8'h00, 32'h13);
		do_halt;
		wmode(3'h2);
		do_wake;
		wmode(3'h6);
		wmode(3'h0);
		check("fast wake source", {30'h0, src}, 32'h1);
		// ==========
		// internal rc: no fast wake, short settle
		high_speed_crystal <= 1'b0;
		do_halt;
		wmode(3'h2);
		do_wake;
		repeat (2) @(posedge clk);
		check("rc wake mode", {29'h0, mode}, 32'h0);
		k = 0;
		while (cpu_run !== 1'b1 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		check("rc settle", {31'h0, (k > 4 && k < 12)}, 32'h1);
		// ==========
		// reset in mid-run
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		check("reset mode", {29'h0, mode}, 32'h0);
		check("reset cpu", {31'h0, cpu_run}, 32'h0);
		check("reset hs enable", {31'h0, hs_en}, 32'h0);
		rst <= 1'b0;
		rd(8'h00, 8'h03);
		stop_test;
	end
endmodule
`default_nettype wire
